// >>> t0ps_defines.svh
// Register indices, field positions, reset values and counts of the timer and shared prescaler.
`ifndef T0PS_DEFINES_SVH
`define T0PS_DEFINES_SVH
`define T0PS_IDX_TIMER       8'h01
`define T0PS_IDX_INTCTL      8'h0B
`define T0PS_IDX_IRQ_MASK    8'h0C
`define T0PS_IDX_CONFIG      8'h81
`define T0PS_CFG_CS_BIT      5
`define T0PS_CFG_EDGE_BIT    4
`define T0PS_CFG_ASSIGN_BIT  3
`define T0PS_CFG_RATE_MSB    2
`define T0PS_CFG_RATE_LSB    0
`define T0PS_INT_EN_BIT      5
`define T0PS_INT_FLAG_BIT    2
`define T0PS_CFG_RESET       8'hFF
`define T0PS_INTCTL_RESET    8'h00
`define T0PS_MASK_RESET      8'h00
`define T0PS_WR_INHIBIT_CYC  2'h2
`endif

// >>> t0ps_pin_model.sv
// Behavioural source of pulses on the external count pin.
`timescale 1ns/10ps
`default_nettype none
module t0ps_pin_model
(
   // Clock
   input  wire logic clk_i,
   // Pin
   output var logic  pin_o
);
   // The pin stands low between bursts.
   initial pin_o = 1'b0;
   // Each level is held whole cycles, so the synchroniser cannot miss it.
   task automatic burst(input int n, input int half);
      for (int i = 0; i < n; i++)
      begin
         repeat (half) @(posedge clk_i);
         pin_o <= 1'b1;
         repeat (half) @(posedge clk_i);
         pin_o <= 1'b0;
      end
   endtask : burst
endmodule : t0ps_pin_model
`default_nettype wire

// >>> t0ps_pkg.sv
// Types shared by the timer and shared prescaler modules.
package t0ps_pkg;
   typedef enum {T0PS_BUS_IDLE, T0PS_BUS_ACK} t0ps_bus_state_type;
endpackage : t0ps_pkg

// >>> t0ps_prescaler.sv
// The single 8-bit prescaler, shared between the counter and the watchdog.
`timescale 1ns/10ps
`default_nettype none
module t0ps_prescaler
#(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // Control
   input  wire logic       to_wdt_i,
   input  wire logic [2:0] rate_i,
   input  wire logic       clear_i,
   input  wire logic       tick_i,
   // Scaled tick
   output logic            out_o
);
   logic [WIDTH-1:0] cnt_q, cnt_d;
   logic [WIDTH:0]   mask;

   function automatic logic [WIDTH:0] rate_mask(input logic wdt, input logic [2:0] n);
      logic [WIDTH:0] m;
      m = (wdt ? ((WIDTH+1)'(1) << n) : ((WIDTH+1)'(2) << n)) - (WIDTH+1)'(1);
      return m;
   endfunction : rate_mask

   always_comb
   begin
      mask = rate_mask(to_wdt_i, rate_i);
      cnt_d = cnt_q;
      if (clear_i)
         cnt_d = '0;
      else if (tick_i)
         cnt_d = cnt_q + WIDTH'(1);
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   // The count has no bus address; only its scaled tick leaves this module.
   assign out_o = tick_i & ~clear_i & (({1'b0, cnt_q} & mask) == mask);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_clear;
      clear_i |=> cnt_q == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("Prescaler not cleared.");
   property p_timer_min;
      out_o && !to_wdt_i |-> cnt_q[0];
   endproperty
   a_timer_min: assert property (p_timer_min) else $error("Timer ratio below 1:2.");
   property p_wdt_pass;
      tick_i && to_wdt_i && rate_i == 3'h0 && !clear_i |-> out_o;
   endproperty
   a_wdt_pass: assert property (p_wdt_pass) else $error("Watchdog 1:1 tick lost.");
endmodule : t0ps_prescaler
`default_nettype wire

// >>> t0ps_sync.sv
// Two-stage synchroniser and edge selector for the external count pin.
`timescale 1ns/10ps
`default_nettype none
module t0ps_sync
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Pin and selection
   input  wire logic pin_i,
   input  wire logic edge_sel_i,
   // Count edge
   output logic      tick_o
);
   logic meta_q, sync_q, prev_q;
   logic meta_d, sync_d, prev_d;

   always_comb
   begin
      meta_d = pin_i;
      sync_d = meta_q;
      prev_d = sync_q;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   // Edges are taken from the settled stage only, so the pin adds two to three cycles of lag.
   assign tick_o = edge_sel_i ? (prev_q & ~sync_q) : (~prev_q & sync_q);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_rise_edge;
      tick_o && !edge_sel_i |-> $past(pin_i, 2) && !$past(pin_i, 3);
   endproperty
   a_rise_edge: assert property (p_rise_edge) else $error("Rising count edge without pin rise.");
   property p_fall_edge;
      tick_o && edge_sel_i |-> !$past(pin_i, 2) && $past(pin_i, 3);
   endproperty
   a_fall_edge: assert property (p_fall_edge) else $error("Falling count edge without pin fall.");
endmodule : t0ps_sync
`default_nettype wire

// >>> t0ps_timer.sv
// Timer and counter with shared prescaler behind a classic Wishbone slave.
`timescale 1ns/10ps
`default_nettype none
`include "t0ps_defines.svh"
module t0ps_timer
   import t0ps_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RSTN_I,
   // Wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [9:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // Core and watchdog
   input  wire logic        SLEEP_I,
   input  wire logic        WDT_BASE_TICK_I,
   input  wire logic        WDT_CLEAR_INSTR_I,
   output logic             WDT_TIMEOUT_O,
   output logic             WDT_CLEAR_O,
   // Count pin
   input  wire logic        EXT_COUNT_PIN_I,
   // Events
   output logic             OVERFLOW_O,
   output logic             IRQ_O
);
   t0ps_bus_state_type bus_q, bus_d;
   logic [31:0] dat_q, dat_d;
   logic [7:0]  count_q, count_d;
   logic [7:0]  cfg_q, cfg_d;
   logic [1:0]  inhibit_q, inhibit_d;
   logic        flag_q, flag_d;
   logic        en_q, en_d;
   logic        mask_q, mask_d;
   logic        ovf_q, ovf_d;
   logic        wdt_to_q, wdt_to_d;
   logic        wdt_clr_q, wdt_clr_d;
   logic        req, acc, wr, rd;
   logic [7:0]  idx;
   logic        timer_wr, intctl_rd;
   logic        src_clk, to_wdt, cs, edge_sel;
   logic [2:0]  rate;
   logic        ext_tick, src_tick, ps_in, ps_out, ps_clear;
   logic        timer_inc, inc_eff, ovf;

   function automatic logic [31:0] read_word(input logic [7:0] i, input logic [7:0] cnt,
                                             input logic [7:0] cfg, input logic en,
                                             input logic flag, input logic msk);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (i)
         `T0PS_IDX_TIMER:    w[7:0] = cnt;
         `T0PS_IDX_CONFIG:   w[7:0] = cfg;
         `T0PS_IDX_INTCTL:
         begin
            w[`T0PS_INT_EN_BIT]   = en;
            w[`T0PS_INT_FLAG_BIT] = flag;
         end
         `T0PS_IDX_IRQ_MASK: w[`T0PS_INT_FLAG_BIT] = msk;
         default:            w = 32'h0000_0000;
      endcase
      return w;
   endfunction : read_word

   // Configuration fields.
   assign cs       = cfg_q[`T0PS_CFG_CS_BIT];
   assign edge_sel = cfg_q[`T0PS_CFG_EDGE_BIT];
   assign to_wdt   = cfg_q[`T0PS_CFG_ASSIGN_BIT];
   assign rate     = cfg_q[`T0PS_CFG_RATE_MSB:`T0PS_CFG_RATE_LSB];

   // Bus decode: an access completes on the edge where ACK is high.
   assign req       = WB_CYC_I & WB_STB_I;
   assign idx       = WB_ADR_I[9:2];
   assign acc       = req & (bus_q == T0PS_BUS_ACK);
   assign wr        = acc & WB_WE_I & WB_SEL_I[0];
   assign rd        = acc & ~WB_WE_I;
   assign timer_wr  = wr & (idx == `T0PS_IDX_TIMER);
   assign intctl_rd = rd & (idx == `T0PS_IDX_INTCTL);

   always_comb
   begin
      bus_d = bus_q;
      dat_d = dat_q;
      case (bus_q)
         T0PS_BUS_IDLE:
         begin
            if (req)
            begin
               bus_d = T0PS_BUS_ACK;
               dat_d = read_word(idx, count_q, cfg_q, en_q, flag_q, mask_q);
            end
         end
         T0PS_BUS_ACK:
            bus_d = T0PS_BUS_IDLE;
         default:
            bus_d = T0PS_BUS_IDLE;
      endcase
   end

   // Count sources.
   t0ps_sync u_sync
   (
      .clk_i      (CLK_SYS_I),
      .rstn_i     (RSTN_I),
      .pin_i      (EXT_COUNT_PIN_I),
      .edge_sel_i (edge_sel),
      .tick_o     (ext_tick)
   );

   // The instruction cycle is one system clock; sleep stops both sources.
   assign src_clk   = ~SLEEP_I;
   assign src_tick  = cs ? (ext_tick & ~SLEEP_I) : src_clk;
   assign ps_in     = to_wdt ? WDT_BASE_TICK_I : src_tick;
   assign ps_clear  = to_wdt ? WDT_CLEAR_INSTR_I : timer_wr;

   t0ps_prescaler #(.WIDTH(8)) u_prescaler
   (
      .clk_i    (CLK_SYS_I),
      .rstn_i   (RSTN_I),
      .to_wdt_i (to_wdt),
      .rate_i   (rate),
      .clear_i  (ps_clear),
      .tick_i   (ps_in),
      .out_o    (ps_out)
   );

   // Without the prescaler the counter takes its source straight.
   assign timer_inc = to_wdt ? src_tick : ps_out;
   assign inc_eff   = timer_inc & (inhibit_q == 2'h0) & ~timer_wr;
   assign ovf       = inc_eff & (count_q == 8'hFF);

   always_comb
   begin
      count_d   = count_q;
      inhibit_d = inhibit_q;
      cfg_d     = cfg_q;
      en_d      = en_q;
      mask_d    = mask_q;
      if (timer_wr)
      begin
         count_d   = WB_DAT_I[7:0];
         inhibit_d = `T0PS_WR_INHIBIT_CYC;
      end
      else
      begin
         if (inc_eff)
            count_d = count_q + 8'h01;
         if (inhibit_q != 2'h0)
            inhibit_d = inhibit_q - 2'h1;
      end
      // Changing the assignment never stalls the counter; software owns the safe order.
      if (wr && idx == `T0PS_IDX_CONFIG)
         cfg_d = WB_DAT_I[7:0];
      if (wr && idx == `T0PS_IDX_INTCTL)
         en_d = WB_DAT_I[`T0PS_INT_EN_BIT];
      if (wr && idx == `T0PS_IDX_IRQ_MASK)
         mask_d = WB_DAT_I[`T0PS_INT_FLAG_BIT];
      // Only a flag already seen by the read is cleared, and a new wrap wins.
      flag_d    = ovf | (flag_q & ~(intctl_rd & dat_q[`T0PS_INT_FLAG_BIT]));
      ovf_d     = ovf;
      wdt_to_d  = to_wdt ? ps_out : WDT_BASE_TICK_I;
      wdt_clr_d = WDT_CLEAR_INSTR_I;
   end

   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         bus_q     <= T0PS_BUS_IDLE;
         dat_q     <= 32'h0000_0000;
         count_q   <= 8'h00;
         inhibit_q <= 2'h0;
         cfg_q     <= `T0PS_CFG_RESET;
         en_q      <= 1'b0;
         mask_q    <= 1'b0;
         flag_q    <= 1'b0;
         ovf_q     <= 1'b0;
         wdt_to_q  <= 1'b0;
         wdt_clr_q <= 1'b0;
      end
      else
      begin
         bus_q     <= bus_d;
         dat_q     <= dat_d;
         count_q   <= count_d;
         inhibit_q <= inhibit_d;
         cfg_q     <= cfg_d;
         en_q      <= en_d;
         mask_q    <= mask_d;
         flag_q    <= flag_d;
         ovf_q     <= ovf_d;
         wdt_to_q  <= wdt_to_d;
         wdt_clr_q <= wdt_clr_d;
      end
   end

   assign WB_ACK_O      = (bus_q == T0PS_BUS_ACK) & req;
   assign WB_DAT_O      = dat_q;
   assign OVERFLOW_O    = ovf_q;
   assign WDT_TIMEOUT_O = wdt_to_q;
   assign WDT_CLEAR_O   = wdt_clr_q;
   assign IRQ_O         = flag_q & en_q & mask_q;

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);

   sequence s_write_quiet;
      timer_wr ##1 !timer_wr ##1 !timer_wr;
   endsequence

   property p_wrap;
      inc_eff && count_q == 8'hFF |=> count_q == 8'h00 && OVERFLOW_O;
   endproperty
   a_wrap: assert property (p_wrap) else $error("Wrap to zero or overflow pulse missing.");
   property p_timer_mode;
      !cs && to_wdt && !SLEEP_I && inhibit_q == 2'h0 && !timer_wr |=> count_q == $past(count_q) + 8'h01;
   endproperty
   a_timer_mode: assert property (p_timer_mode) else $error("Timer mode missed a cycle.");
   property p_inhibit;
      s_write_quiet |=> count_q == $past(WB_DAT_I[7:0], 3);
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("Count moved inside the write hold-off.");
   property p_flag;
      ovf |=> flag_q;
   endproperty
   a_flag: assert property (p_flag) else $error("Overflow did not set the flag.");
   property p_flag_hold;
      flag_q && !intctl_rd |=> flag_q;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("Flag cleared without a read.");
   property p_sleep;
      SLEEP_I && !timer_wr |=> $stable(count_q);
   endproperty
   a_sleep: assert property (p_sleep) else $error("Counter moved during sleep.");
   property p_wdt_clear;
      to_wdt && WDT_CLEAR_INSTR_I |=> WDT_CLEAR_O;
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) else $error("Watchdog clear not passed on.");

   // Paths that the bench only sees from outside, such as the prescaler tick, are checked here.
   sequence s_bus_request;
      req && bus_q == T0PS_BUS_IDLE ##1 req;
   endsequence

   sequence s_pin_step;
      cs && to_wdt && ext_tick && !SLEEP_I;
   endsequence

   property p_ack_once;
      s_bus_request |-> WB_ACK_O ##1 !WB_ACK_O;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("Bus answer not one cycle after the request.");
   property p_cfg_write;
      wr && idx == `T0PS_IDX_CONFIG |=> cfg_q == $past(WB_DAT_I[7:0]);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("Configuration write did not land.");
   property p_unmapped;
      WB_ACK_O && !WB_WE_I && !(idx inside {`T0PS_IDX_TIMER, `T0PS_IDX_INTCTL, `T0PS_IDX_IRQ_MASK,
                                            `T0PS_IDX_CONFIG}) |-> WB_DAT_O == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("Unmapped read returned data.");
   property p_pin_count;
      s_pin_step ##0 (inhibit_q == 2'h0 && !timer_wr) |=> count_q == $past(count_q) + 8'h01;
   endproperty
   a_pin_count: assert property (p_pin_count) else $error("Pin edge did not advance the counter.");
   property p_flag_clear;
      intctl_rd && dat_q[`T0PS_INT_FLAG_BIT] && !ovf |=> !flag_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("Read of a set flag did not clear it.");
   property p_ps_clear;
      timer_wr && !to_wdt |=> !ps_out;
   endproperty
   a_ps_clear: assert property (p_ps_clear) else $error("Prescaler tick right after a counter write.");
   property p_raw_wdt;
      !to_wdt && WDT_BASE_TICK_I |=> WDT_TIMEOUT_O;
   endproperty
   a_raw_wdt: assert property (p_raw_wdt) else $error("Unscaled watchdog tick lost.");
   property p_wdt_direct;
      to_wdt && rate == 3'h0 && WDT_BASE_TICK_I && !WDT_CLEAR_INSTR_I |=> WDT_TIMEOUT_O;
   endproperty
   a_wdt_direct: assert property (p_wdt_direct) else $error("Watchdog 1:1 timeout missing.");
endmodule : t0ps_timer
`default_nettype wire

// >>> t0ps_timer_bench.sv
// Self-checking bench for the timer with shared prescaler.
`timescale 1ns/10ps
`default_nettype none
`include "t0ps_defines.svh"
module t0ps_timer_bench;
   localparam logic [9:0] A_TMR = {`T0PS_IDX_TIMER, 2'b00};
   localparam logic [9:0] A_INT = {`T0PS_IDX_INTCTL, 2'b00};
   localparam logic [9:0] A_MSK = {`T0PS_IDX_IRQ_MASK, 2'b00};
   localparam logic [9:0] A_CFG = {`T0PS_IDX_CONFIG, 2'b00};
   logic        clk, rstn, cyc, stb, we, sleep, wtick, wclr;
   logic [9:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat_w, rd;
   logic [7:0]  a, b;
   int          c, err_total, n_compared;
   wire logic [31:0] dat_r;
   wire logic        ack, wto, wco, pin, ovf, irq;

   t0ps_timer u_t0ps_timer (.CLK_SYS_I(clk), .RSTN_I(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .SLEEP_I(sleep),
      .WDT_BASE_TICK_I(wtick), .WDT_CLEAR_INSTR_I(wclr), .WDT_TIMEOUT_O(wto), .WDT_CLEAR_O(wco),
      .EXT_COUNT_PIN_I(pin), .OVERFLOW_O(ovf), .IRQ_O(irq));
   t0ps_pin_model u_t0ps_pin_model (.clk_i(clk), .pin_o(pin));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Classic cycle: held until ack is sampled high at a rising edge.
   task automatic bus(input logic w, input logic [9:0] ad, input logic [7:0] d, input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      sel <= s;
      dat_w <= {24'h0, d};
      @(posedge clk iff ack === 1'b1);
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : bus

   task automatic wr(input logic [9:0] ad, input logic [7:0] d);
      bus(1'b1, ad, d, 4'h1);
   endtask : wr

   task automatic rchk(input logic [9:0] ad, input logic [7:0] e);
      bus(1'b0, ad, 8'h00, 4'h1);
      check(rd, {24'h0, e});
   endtask : rchk

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle

   task automatic count_to(input int n);
      c = 0;
      repeat (n)
      begin
         @(negedge clk);
         if (wto === 1'b1)
            c++;
      end
   endtask : count_to

   task automatic t_regs;
      rchk(A_TMR, 8'h00);
      rchk(A_CFG, `T0PS_CFG_RESET);
      rchk(A_INT, `T0PS_INTCTL_RESET);
      rchk(A_MSK, `T0PS_MASK_RESET);
      wr(A_CFG, 8'h5A);
      rchk(A_CFG, 8'h5A);
      bus(1'b1, A_CFG, 8'h11, 4'hE);
      rchk(A_CFG, 8'h5A);
      wr(10'h3FC, 8'h33);
      rchk(10'h3FC, 8'h00);
      $display("test registers done");
   endtask : t_regs

   task automatic t_timer;
      wr(A_CFG, 8'h08);
      wr(A_TMR, 8'h10);
      idle(1);
      rchk(A_TMR, 8'h10);
      wr(A_TMR, 8'h10);
      idle(5);
      rchk(A_TMR, 8'h14);
      bus(1'b0, A_TMR, 8'h00, 4'h1);
      a = rd[7:0];
      idle(7);
      bus(1'b0, A_TMR, 8'h00, 4'h1);
      b = rd[7:0];
      check({24'h0, b - a}, 32'h0A);
      $display("test timer done");
   endtask : t_timer

   task automatic t_overflow;
      wr(A_INT, 8'h20);
      wr(A_TMR, 8'hFE);
      idle(3);
      @(negedge clk);
      check(ovf, 1'b0);
      @(negedge clk);
      check(ovf, 1'b1);
      @(negedge clk);
      check(ovf, 1'b0);
      check(irq, 1'b0);
      wr(A_MSK, 8'h04);
      idle(20);
      check(irq, 1'b1);
      rchk(A_INT, 8'h24);
      idle(1);
      check(irq, 1'b0);
      rchk(A_INT, 8'h20);
      wr(A_INT, 8'h00);
      $display("test overflow done");
   endtask : t_overflow

   // Reads spaced by whole prescaler periods differ by the period count whatever the phase.
   task automatic t_prescale;
      for (int n = 0; n < 8; n++)
      begin
         wr(A_CFG, n[7:0]);
         bus(1'b0, A_TMR, 8'h00, 4'h1);
         a = rd[7:0];
         idle(8 * (2 << n) - 3);
         bus(1'b0, A_TMR, 8'h00, 4'h1);
         b = rd[7:0];
         check({24'h0, b - a}, 32'h08);
      end
      wr(A_TMR, 8'h40);
      idle(200);
      wr(A_TMR, 8'h40);
      idle(240);
      rchk(A_TMR, 8'h40);
      idle(20);
      rchk(A_TMR, 8'h41);
      $display("test prescaler done");
   endtask : t_prescale

   task automatic t_pin;
      wr(A_TMR, 8'h00);
      wr(A_CFG, 8'h28);
      wr(A_TMR, 8'h00);
      u_t0ps_pin_model.burst(5, 3);
      idle(6);
      rchk(A_TMR, 8'h05);
      wr(A_CFG, 8'h38);
      wr(A_TMR, 8'h00);
      u_t0ps_pin_model.burst(5, 3);
      idle(6);
      rchk(A_TMR, 8'h05);
      $display("test pin done");
   endtask : t_pin

   task automatic t_sleep;
      wr(A_CFG, 8'h08);
      sleep <= 1'b1;
      bus(1'b0, A_TMR, 8'h00, 4'h1);
      a = rd[7:0];
      idle(10);
      bus(1'b0, A_TMR, 8'h00, 4'h1);
      check({24'h0, rd[7:0]}, {24'h0, a});
      sleep <= 1'b0;
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_watchdog;
      wtick <= 1'b1;
      for (int n = 0; n < 8; n++)
      begin
         wr(A_CFG, 8'h08 | n[7:0]);
         idle((1 << n) + 3);
         count_to(8 << n);
         check(c, 8);
      end
      wr(A_CFG, 8'h00);
      idle(2);
      count_to(16);
      check(c, 16);
      wr(A_TMR, 8'h00);
      wr(A_CFG, 8'h0B);
      wclr <= 1'b1;
      @(posedge clk);
      wclr <= 1'b0;
      @(negedge clk);
      check(wco, 1'b1);
      count_to(5);
      check(c, 0);
      count_to(6);
      check(c, 1);
      wtick <= 1'b0;
      $display("test watchdog done");
   endtask : t_watchdog

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   initial
   begin
      {rstn, cyc, stb, we, sleep, wtick, wclr} = 7'h00;
      adr = 10'h000;
      sel = 4'h0;
      dat_w = 32'h0;
      err_total = 0;
      n_compared = 0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_regs;
      t_timer;
      t_overflow;
      t_prescale;
      t_pin;
      t_sleep;
      t_watchdog;
      conclude;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      conclude;
   end
endmodule : t0ps_timer_bench
`default_nettype wire
